// *** src/ccd_line_scan_timing_gen.sv ***
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module ccd_line_scan_timing_gen
	import scan_timing_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic ext_clock_in,
	input wire logic ext_expo_end,
	output logic pixel_reset_clock,
	output logic transport_clock,
	output logic line_transfer_clock,
	output logic white_ref_clock,
	output logic scan_end_marker
);
	logic [2:0] ctrl;
	logic [15:0] rate_div;
	logic [15:0] expo_us;
	logic [15:0] lines;
	logic [2:0] clk_sync;
	logic [2:0] end_sync;
	logic ext_clk_rise;
	logic ext_end_rise;
	logic int_data_tick;
	logic us_tick;
	logic data_tick;
	logic tck_tick;
	logic [15:0] rate_clamped;
	logic [15:0] expo_clamped;
	logic [15:0] rck_count;
	logic [15:0] expo_cnt;
	logic expo_pending;
	logic int_expo_end;
	scan_state_e state;
	logic [6:0] rd_cnt;
	logic clk_sel;
	logic exp_sel;
	logic run;

	function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	assign clk_sel = ctrl[CTRL_CLK_SEL];
	assign exp_sel = ctrl[CTRL_EXP_SEL];
	assign run = ctrl[CTRL_RUN];
	assign rate_clamped = clamp16(rate_div, DIV_MIN, DIV_MAX);
	assign expo_clamped = clamp16(expo_us, EXPO_MIN_US, EXPO_MAX_US);

	// Pins are asynchronous; the second and third stages feed the edge detector
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			clk_sync <= 3'h0;
			end_sync <= 3'h0;
		end
		else
		begin
			clk_sync <= {clk_sync[1:0], ext_clock_in};
			end_sync <= {end_sync[1:0], ext_expo_end};
		end
	end
	assign ext_clk_rise = clk_sync[1] && !clk_sync[2];
	assign ext_end_rise = end_sync[1] && !end_sync[2];

	rate_divider u_rate (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.enable(run && !clk_sel),
		.period(rate_clamped),
		.tick(int_data_tick)
	);

	rate_divider u_us (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.enable(run),
		.period(US_CYCLES),
		.tick(us_tick)
	);

	assign data_tick = run && (clk_sel ? ext_clk_rise : int_data_tick);
	// Transport clock rising edge is the readout step unit
	assign tck_tick = data_tick && !transport_clock;

	// Register port
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			ctrl <= CTRL_RST;
			rate_div <= RATE_RST;
			expo_us <= EXPO_RST;
		end
		else if (wr)
		begin
			case (addr)
				ADDR_CTRL: ctrl <= wdata[2:0];
				ADDR_RATE: rate_div <= wdata[15:0];
				ADDR_EXPO: expo_us <= wdata[15:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			rdata <= 32'h0000_0000;
		else if (rd)
		begin
			case (addr)
				ADDR_CTRL: rdata <= {29'h0, ctrl};
				// Reads show the setting in effect, so software sees the clamp
				ADDR_RATE: rdata <= {16'h0, rate_clamped};
				ADDR_EXPO: rdata <= {16'h0, expo_clamped};
				ADDR_STATUS: rdata <= {8'h00, rd_cnt, 13'h0, expo_pending, state, transport_clock};
				ADDR_LINES: rdata <= {16'h0, lines};
				default: rdata <= 32'h0000_0000;
			endcase
		end
		else
			rdata <= 32'h0000_0000;
	end

	// Reset clock: half period internal, fixed short pulse on an external clock
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			pixel_reset_clock <= 1'b0;
			rck_count <= 16'h0000;
		end
		else if (data_tick)
		begin
			pixel_reset_clock <= 1'b1;
			rck_count <= clk_sel ? RCK_EXT_WIDTH : {1'b0, rate_clamped[15:1]};
		end
		else if (rck_count > 16'h0001)
			rck_count <= rck_count - 16'h0001;
		else
		begin
			rck_count <= 16'h0000;
			pixel_reset_clock <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			transport_clock <= 1'b0;
		else if (data_tick)
			transport_clock <= !transport_clock;
	end

	// Internal exposure countdown in microseconds, reloaded at terminal count
	assign int_expo_end = !exp_sel && us_tick && expo_cnt == 16'h0001;
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			expo_cnt <= EXPO_RST;
		else if (exp_sel || expo_cnt == 16'h0000)
			expo_cnt <= expo_clamped;
		else if (us_tick)
			expo_cnt <= (expo_cnt == 16'h0001) ? expo_clamped : expo_cnt - 16'h0001;
	end

	// Set wins over the clear taken by the transfer start
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			expo_pending <= 1'b0;
		else if (int_expo_end || (exp_sel && ext_end_rise))
			expo_pending <= 1'b1;
		else if (tck_tick)
			expo_pending <= 1'b0;
	end

	// Line readout, advanced on transport clock rising edges
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			state <= ST_IDLE;
			rd_cnt <= 7'h00;
		end
		else if (tck_tick)
		begin
			if (expo_pending)
			begin
				state <= ST_TRANSFER;
				rd_cnt <= 7'h00;
			end
			else
			begin
				case (state)
					ST_TRANSFER:
					begin
						state <= ST_READ;
						rd_cnt <= 7'h01;
					end
					ST_READ:
					begin
						if (rd_cnt == END_TCK)
							state <= ST_IDLE;
						rd_cnt <= rd_cnt + 7'h01;
					end
					ST_IDLE: rd_cnt <= 7'h00;
					default: state <= ST_IDLE;
				endcase
			end
		end
	end

	// Outputs follow the state one cycle later, straight from flops
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			line_transfer_clock <= 1'b0;
			white_ref_clock <= 1'b0;
			scan_end_marker <= 1'b0;
		end
		else
		begin
			line_transfer_clock <= state == ST_TRANSFER;
			white_ref_clock <= state == ST_READ && rd_cnt == WHITE_TCK;
			scan_end_marker <= state == ST_READ && rd_cnt == END_TCK;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			lines <= 16'h0000;
		else if (tck_tick && expo_pending)
			lines <= lines + 16'h0001;
	end

	// Helper for checks: transport ticks since the last transfer start
	logic [7:0] tck_since;
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			tck_since <= 8'h00;
		else if (tck_tick && expo_pending)
			tck_since <= 8'h00;
		else if (tck_tick && tck_since != 8'hff)
			tck_since <= tck_since + 8'h01;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	a_rate_range: assert property (rate_clamped >= DIV_MIN && rate_clamped <= DIV_MAX)
		else $error("pixel rate divider out of range");
	a_ext_clk_only: assert property (clk_sel && !ext_clk_rise |-> !data_tick)
		else $error("data tick without external clock edge");
	a_expo_range: assert property (expo_clamped >= EXPO_MIN_US && expo_clamped <= EXPO_MAX_US)
		else $error("internal exposure out of range");
	a_ext_expo_end: assert property (exp_sel && ext_end_rise |=> expo_pending)
		else $error("external exposure end not taken");
	a_tck_half: assert property (data_tick |=> transport_clock != $past(transport_clock))
		else $error("transport clock did not toggle on data tick");
	a_tck_hold: assert property (!data_tick |=> $stable(transport_clock))
		else $error("transport clock moved without data tick");
	a_rck_tick: assert property (data_tick |=> pixel_reset_clock)
		else $error("reset clock missing after data tick");
	a_expo_reload: assert property (int_expo_end |=> expo_cnt == $past(expo_clamped))
		else $error("exposure counter not reloaded");
	a_xfer_start: assert property (tck_tick && expo_pending |=> ##1 line_transfer_clock)
		else $error("no transfer pulse after exposure end");
	a_white_pos: assert property ($rose(white_ref_clock) |-> tck_since == 8'(WHITE_TCK))
		else $error("white reference at wrong readout position");
	a_end_after_white: assert property (state == ST_READ && rd_cnt == WHITE_TCK && tck_tick
		&& !expo_pending |=> ##1 scan_end_marker)
		else $error("scan end marker not after white reference");

	c_int_line: cover property (!exp_sel && $rose(white_ref_clock));
	c_ext_expo: cover property (exp_sel && ext_end_rise ##[1:1000] line_transfer_clock);
	c_ext_clock: cover property (clk_sel && data_tick ##[1:1000] tck_tick);
endmodule // ccd_line_scan_timing_gen

// *** src/scan_timing_pkg.sv ***
package scan_timing_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int US_PER_S = 1_000_000;
	localparam int RATE_MIN_HZ = 200_000;
	localparam int RATE_MAX_HZ = 2_000_000;
	localparam logic [15:0] DIV_MAX = 16'(CLK_HZ / RATE_MIN_HZ);
	localparam logic [15:0] DIV_MIN = 16'(CLK_HZ / RATE_MAX_HZ);
	localparam logic [15:0] US_CYCLES = 16'(CLK_HZ / US_PER_S);
	localparam int EXPO_MIN_MS = 2;
	localparam int EXPO_MAX_MS = 16;
	localparam logic [15:0] EXPO_MIN_US = 16'(EXPO_MIN_MS * 1000);
	localparam logic [15:0] EXPO_MAX_US = 16'(EXPO_MAX_MS * 1000);
	localparam int READOUT_DATA = 161;
	localparam logic [6:0] READOUT_TCK = 7'((READOUT_DATA + 1) / 2);
	localparam logic [6:0] WHITE_TCK = READOUT_TCK - 7'h2;
	localparam logic [6:0] END_TCK = READOUT_TCK - 7'h1;
	localparam logic [15:0] RCK_EXT_WIDTH = 16'h0005;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_RATE = 8'h04;
	localparam logic [7:0] ADDR_EXPO = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_LINES = 8'h10;
	localparam int CTRL_CLK_SEL = 0;
	localparam int CTRL_EXP_SEL = 1;
	localparam int CTRL_RUN = 2;
	localparam logic [2:0] CTRL_RST = 3'h4;
	localparam logic [15:0] RATE_RST = 16'h00c8;
	localparam logic [15:0] EXPO_RST = 16'h2710;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_TRANSFER = 2'b01,
		ST_READ = 2'b10
	} scan_state_e;
endpackage

// *** src/rate_divider.sv ***
`timescale 1ns/1ps
module rate_divider
	import scan_timing_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic enable,
	input wire logic [15:0] period,
	output logic tick
);
	logic [15:0] count;

	always_ff @(posedge sys_clk)
	begin
		if (!nrst || !enable)
		begin
			count <= 16'h0000;
			tick <= 1'b0;
		end
		else if (count + 16'h0001 >= period)
		begin
			count <= 16'h0000;
			tick <= 1'b1;
		end
		else
		begin
			count <= count + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule // rate_divider

// *** verif/ext_expo_chain.sv ***
`timescale 1ns/1ps
module ext_expo_chain
(
	input wire logic transport_clock,
	input wire logic nrst,
	input wire logic [11:0] preset,
	output logic ext_expo_end = 1'b0
);
	logic [11:0] count = 12'h000;

	// Preset change only lands at the next terminal count, as in a real chain
	always @(posedge transport_clock or negedge nrst)
	begin
		if (!nrst)
		begin
			count <= preset;
			ext_expo_end <= 1'b0;
		end
		else if (count <= 12'h001)
		begin
			count <= preset;
			ext_expo_end <= 1'b1;
		end
		else
		begin
			count <= count - 12'h001;
			ext_expo_end <= 1'b0;
		end
	end
endmodule // ext_expo_chain

// *** verif/ccd_line_scan_timing_gen_tb.sv ***
`timescale 1ns/1ps
module ccd_line_scan_timing_gen_tb;
	import scan_timing_pkg::*;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic ext_clock_in = 1'b0;
	logic [4:0] ext_div = 5'h00;
	logic [11:0] preset = 12'h051;
	logic [31:0] rdata;
	logic ext_expo_end, pixel_reset_clock, transport_clock;
	logic line_transfer_clock, white_ref_clock, scan_end_marker;
	logic [31:0] v;
	int errors = 0;
	int compares = 0;
	int seed = 12;
	int n, lt, r, p;

	initial
	begin
		forever #5 sys_clk = ~sys_clk;
	end

	// External data clock, 40 system cycles per period
	always @(posedge sys_clk)
	begin
		ext_div <= (ext_div == 5'h13) ? 5'h00 : ext_div + 5'h01;
		if (ext_div == 5'h13)
			ext_clock_in <= ~ext_clock_in;
	end

	ccd_line_scan_timing_gen i_ccd_line_scan_timing_gen (.sys_clk(sys_clk), .nrst(nrst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.ext_clock_in(ext_clock_in), .ext_expo_end(ext_expo_end),
		.pixel_reset_clock(pixel_reset_clock), .transport_clock(transport_clock),
		.line_transfer_clock(line_transfer_clock), .white_ref_clock(white_ref_clock),
		.scan_end_marker(scan_end_marker));

	ext_expo_chain i_ext_expo_chain (.transport_clock(transport_clock), .nrst(nrst),
		.preset(preset), .ext_expo_end(ext_expo_end));

	function automatic int clamp(input int x, input int lo, input int hi);
		return (x < lo) ? lo : ((x > hi) ? hi : x);
	endfunction

	function automatic logic sig(input int s);
		return (s == 0) ? pixel_reset_clock : ((s == 1) ? transport_clock : white_ref_clock);
	endfunction

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		@(posedge sys_clk);
		d = rdata;
	endtask

	// Two rises are skipped so a period cut short by a setting change is not measured
	task automatic gap(input int s, output int n, output int lt);
		logic q, ql;
		int t;
		t = 0;
		repeat (2)
		begin
			do begin q = sig(s); @(posedge sys_clk); t++; end while (!(sig(s) && !q) && t < 40000);
		end
		n = 0;
		lt = 0;
		do
		begin
			q = sig(s);
			ql = line_transfer_clock;
			@(posedge sys_clk);
			n++;
			lt += (line_transfer_clock === 1'b1 && ql === 1'b0) ? 1 : 0;
		end
		while (!(sig(s) && !q) && n < 40000);
	endtask

	task automatic wrap_up;
		if (errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		#900000;
		errors++;
		wrap_up();
	end

	initial
	begin
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		rd_reg(ADDR_CTRL, v); chk("ctrl_reset", v, 32'(CTRL_RST));
		rd_reg(ADDR_RATE, v); chk("rate_reset", v, 32'(RATE_RST));
		rd_reg(ADDR_EXPO, v); chk("expo_reset", v, 32'(EXPO_RST));
		rd_reg(8'h14, v); chk("unmapped", v, 32'h0);
		for (int i = 0; i < 2; i++)
		begin
			r = i ? 20000 : 100;
			wr_reg(ADDR_EXPO, 32'(r)); rd_reg(ADDR_EXPO, v);
			chk("expo_clamp", v, 32'(clamp(r, 2000, 16000)));
			r = i ? 1000 : 10;
			wr_reg(ADDR_RATE, 32'(r)); rd_reg(ADDR_RATE, v);
			chk("rate_clamp", v, 32'(clamp(r, 50, 500)));
		end
		for (int i = 0; i < 3; i++)
		begin
			r = (i == 0) ? 50 : ((i == 1) ? 500 : 50 + int'($unsigned($random(seed)) % 451));
			wr_reg(ADDR_RATE, 32'(r));
			gap(0, n, lt); chk("reset_period", 32'(n), 32'(r));
			gap(1, n, lt); chk("transport_period", 32'(n), 32'(2 * r));
		end
		wr_reg(ADDR_CTRL, 32'h5);
		gap(0, n, lt); chk("ext_reset_period", 32'(n), 32'd40);
		gap(1, n, lt); chk("ext_transport_period", 32'(n), 32'd80);
		wr_reg(ADDR_CTRL, 32'h0);
		repeat (20) @(posedge sys_clk);
		n = 0;
		repeat (200)
		begin
			@(posedge sys_clk);
			n += (pixel_reset_clock === 1'b0) ? 0 : 1;
		end
		chk("stopped", 32'(n), 32'h0);
		// Second reset with the generator stopped: outputs drop and the control word returns
		nrst <= 1'b0;
		repeat (12) @(posedge sys_clk);
		chk("reset_outputs", {27'h0, pixel_reset_clock, transport_clock, line_transfer_clock,
			white_ref_clock, scan_end_marker}, 32'h0);
		nrst <= 1'b1;
		rd_reg(ADDR_CTRL, v); chk("ctrl_rereset", v, 32'(CTRL_RST));
		wr_reg(ADDR_RATE, 32'd50);
		wr_reg(ADDR_CTRL, 32'h6);
		for (int i = 0; i < 2; i++)
		begin
			p = i ? 81 + int'($unsigned($random(seed)) % 20) : 81;
			preset <= 12'(p);
			gap(2, n, lt); chk("expo_period", 32'(n), 32'(p * 2 * 50));
			chk("transfers_per_line", 32'(lt), 32'h1);
			n = 0;
			while (scan_end_marker !== 1'b1 && n < 400)
			begin
				@(posedge sys_clk);
				n++;
			end
			chk("end_after_white", 32'(n), 32'(2 * 50));
		end
		wrap_up();
	end
endmodule // ccd_line_scan_timing_gen_tb
